//--- tbu_host_model.sv
/* Host model: queues transmit buffer words and offers them to the FIFO.
   Assumes in_ready is sampled on the rising edge of clk. */
`timescale 1ns/1ps
`default_nettype none
module tbu_host_model (
    input  wire logic   clk,      // System clock
    input  wire logic   in_ready, // Word taken
    output logic [31:0] in_data,  // FIFO word
    output logic        in_valid  // Word present
);
    import tbu_pkg::*;
    logic [31:0] q[$];
    initial begin
        in_valid = 1'b0;
        in_data  = 32'h0;
    end
    ////////////////////////////////////////
    // Idle gaps only between words; idle data toggles so stale never helps
    always @(posedge clk) begin
        if (in_valid && in_ready)
            void'(q.pop_front());
        if (!in_valid || in_ready) begin
            if (q.size() > 0 && $urandom_range(3) != 0) begin
                in_valid <= 1'b1;
                in_data  <= q[0];
            end else begin
                in_valid <= 1'b0;
                in_data  <= ~in_data;
            end
        end
    end
    task put_buf(input logic [31:0] a, b, input logic [7:0] pl[$]);
        int          ofs, tot, g, n;
        logic [31:0] w;
        ofs = int'(a[20:16]);
        tot = ofs + pl.size();
        g   = (a[25:24] == ALIGN_16) ? 16 : (a[25:24] == ALIGN_32) ? 32 : 4;
        n   = (tot + g - 1) / g * g / 4;
        q.push_back(a);
        if (a[CMDA_FS_BIT])
            q.push_back(b);
        for (int i = 0; i < 4 * n; i++) begin
            w[8*(i%4) +: 8] = (i >= ofs && i < tot) ? pl[i-ofs] : 8'($urandom);
            if (i % 4 == 3)
                q.push_back(w);
        end
    endtask : put_buf
endmodule : tbu_host_model
`default_nettype wire

//--- tbu_lane_ser.sv
/*
 * Serialiser: takes one FIFO word with a first and last byte lane and
 * hands out those bytes, lowest lane first, one per accepted cycle.
 * Assumes the consumer holds out_ready as a plain level on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tbu_lane_ser (
    input  wire logic        clk,       // System clock
    input  wire logic        nrst,      // Synchronous reset, active low
    input  wire logic        ld_valid,  // Word offered
    output logic             ld_ready,  // Word can be taken
    input  wire logic [31:0] ld_word,   // Word to split
    input  wire logic [1:0]  ld_lo,     // First lane to send
    input  wire logic [1:0]  ld_hi,     // Last lane to send
    input  wire logic        ld_last,   // Word ends the packet
    output logic [7:0]       out_byte,  // Byte to the transmit store
    output logic             out_valid, // Byte present
    output logic             out_last,  // Final byte of the packet
    input  wire logic        out_ready  // Store accepts the byte
);
    import tbu_pkg::*;

    typedef struct packed {
        logic [31:0] word;
        logic [1:0]  cur;
        logic [1:0]  hi;
        logic        last;
        logic        busy;
        logic [7:0]  byte_q;
    } tbu_ser_t;

    tbu_ser_t st_r;
    tbu_ser_t st_nxt;
    logic     end_of_word;

    assign end_of_word = st_r.busy && out_ready && (st_r.cur == st_r.hi);
    // Taking the next word on the last byte keeps one byte per cycle
    assign ld_ready    = !st_r.busy || end_of_word;
    assign out_valid   = st_r.busy;
    assign out_byte    = st_r.byte_q;
    assign out_last    = st_r.busy && st_r.last && (st_r.cur == st_r.hi);

    always_comb begin
        st_nxt = st_r;
        if (ld_valid && ld_ready) begin
            st_nxt.word   = ld_word;
            st_nxt.cur    = ld_lo;
            st_nxt.hi     = ld_hi;
            st_nxt.last   = ld_last;
            st_nxt.busy   = 1'b1;
            st_nxt.byte_q = ld_word[8*ld_lo +: 8];
        end else if (end_of_word) begin
            st_nxt.busy = 1'b0;
        end else if (st_r.busy && out_ready) begin
            st_nxt.cur    = st_r.cur + 2'h1;
            st_nxt.byte_q = st_r.word[8*(st_r.cur + 2'h1) +: 8];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    AST_FIRST_LANE: assert property (@(posedge clk) disable iff (!nrst)
        (ld_valid && ld_ready) |=>
            (out_valid && out_byte == $past(ld_word[8*ld_lo +: 8])))
        else $error("first byte not taken from the selected lane");
endmodule : tbu_lane_ser
`default_nettype wire

//--- tbu_len_chk.sv
/*
 * Length checker: sums buffer byte counts over one packet and compares
 * the sum with the packet length once the packet's last buffer is done.
 * Assumes the length load comes after the first add of the packet.
 */
`timescale 1ns/1ps
`default_nettype none
module tbu_len_chk (
    input  wire logic                      clk,       // System clock
    input  wire logic                      nrst,      // Sync reset, low
    input  wire logic                      add_v,     // Buffer count valid
    input  wire logic                      add_first, // Buffer opens packet
    input  wire logic [tbu_pkg::CNT_W-1:0] add_cnt,   // Buffer byte count
    input  wire logic                      plen_v,    // Packet length valid
    input  wire logic [tbu_pkg::CNT_W-1:0] plen,      // Packet length
    input  wire logic                      chk_v,     // Last buffer done
    output logic                           err        // Mismatch, one pulse
);
    import tbu_pkg::*;

    typedef struct packed {
        logic [11:0]      sum;
        logic [CNT_W-1:0] plen;
        logic             err;
    } tbu_len_t;

    tbu_len_t st_r;
    tbu_len_t st_nxt;

    assign err = st_r.err;

    always_comb begin
        st_nxt     = st_r;
        st_nxt.err = 1'b0;
        if (add_v) begin
            if (add_first) begin
                st_nxt.sum = {1'b0, add_cnt};
            end else begin
                st_nxt.sum = st_r.sum + {1'b0, add_cnt};
            end
        end
        if (plen_v) begin
            st_nxt.plen = plen;
        end
        if (chk_v) begin
            st_nxt.err = (st_r.sum != {1'b0, st_r.plen});
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    AST_MISMATCH: assert property (@(posedge clk) disable iff (!nrst)
        chk_v |=> (err == ($past(st_r.sum) != {1'b0, $past(st_r.plen)})))
        else $error("length mismatch not flagged correctly");
endmodule : tbu_len_chk
`default_nettype wire

//--- tbu_pkg.sv
/*
 * Shared constants for the transmit buffer command unpacker: command word
 * field positions, register map, reset values and the parser state type.
 * Assumes a 32-bit host FIFO word and a byte-wide transmit store.
 */
`default_nettype none
package tbu_pkg;
    // Command A fields
    localparam int CMDA_IOC_BIT   = 31;
    localparam int CMDA_ALIGN_LSB = 24;
    localparam int CMDA_OFS_LSB   = 16;
    localparam int CMDA_FS_BIT    = 13;
    localparam int CMDA_LS_BIT    = 12;
    localparam int CNT_W          = 11;
    // Command B fields
    localparam int CMDB_TAG_LSB   = 16;
    localparam int CMDB_CK_BIT    = 14;
    localparam int CMDB_NOCRC_BIT = 13;
    localparam int CMDB_NOPAD_BIT = 12;
    localparam int MIN_FRAME_BYTES = 64;
    // End alignment codes and the byte masks they imply
    localparam logic [1:0]  ALIGN_16 = 2'h1;
    localparam logic [1:0]  ALIGN_32 = 2'h2;
    localparam logic [11:0] MASK_4   = 12'h003;
    localparam logic [11:0] MASK_16  = 12'h00F;
    localparam logic [11:0] MASK_32  = 12'h01F;
    // Register map, byte addresses
    localparam int          ADDR_W   = 4;
    localparam logic [3:0]  REG_CTRL = 4'h0;
    localparam logic [3:0]  REG_STAT = 4'h4;
    localparam logic [3:0]  REG_TAG  = 4'h8;
    localparam int          CTRL_CSUM_EN_BIT = 0;
    localparam int          STAT_ERR_BIT     = 0;
    localparam int          STAT_LOADED_BIT  = 1;
    localparam logic        CTRL_CSUM_EN_RST = 1'b0;
    // Parser states, Gray along A -> B -> skip -> data -> pad
    typedef enum logic [2:0] {
        ST_CMDA = 3'h0,
        ST_CMDB = 3'h1,
        ST_SKIP = 3'h3,
        ST_DATA = 3'h2,
        ST_PAD  = 3'h6
    } tbu_state_t;
endpackage : tbu_pkg
`default_nettype wire

//--- tbu_unpacker.sv
/*
 * Transmit buffer command unpacker: parses command A / command B words
 * from the host FIFO, drops offset and alignment filler, forwards payload
 * bytes, carries per-packet options and keeps a small register file.
 * Assumes the FIFO and the transmit store share clk with this block.
 */
// Operation
// - Command A bit 13 marks first segment, bit 12 last segment.
// - Byte count A[10:0] with end alignment gives trailing filler words.
// - Sum buffer counts per packet, compare with command B length.
// - Command B length is payload bytes only, no offset or filler.
// - Raise transmit error when supplied bytes differ from packet length.
// - Copy command B tag bits 31:16 into the packet status.
// - Checksum request needs B bit 14, first segment and engine enable.
// - Command B bit 13 suppresses the appended frame CRC.
// - Command B bit 12 stops padding of frames under 64 bytes.
// - With padding suppressed the CRC is appended regardless.
// - Payload starts at the third word, after commands A and B; with no first segment there is no B, so payload starts at the second.
// - Offset bits 1:0 select the lane of the first payload byte.
// - Offset upper bits skip 0 to 7 whole words, never forwarded.
// - Payload is contiguous, trailing unused bytes are not forwarded.
// - Each buffer ends padded to 4, 16 or 32 byte alignment.
// - Alignment filler is discarded, never forwarded.
// - Alignment code 00 4-byte, 01 16-byte, 10 32-byte, 11 reserved.
// - Command A bit 31 raises buffer-loaded once the buffer is taken.
// - Command B follows only a command A with first segment set.
`timescale 1ns/1ps
`default_nettype none
module tbu_unpacker (
    input  wire logic                       clk,          // System clock
    input  wire logic                       nrst,         // Sync reset, low
    input  wire logic [31:0]                in_data,      // Host FIFO word
    input  wire logic                       in_valid,     // Word present
    output logic                            in_ready,     // Word taken
    output logic [7:0]                      out_byte,     // Payload byte
    output logic                            out_valid,    // Byte present
    output logic                            out_last,     // End of packet
    input  wire logic                       out_ready,    // Store accepts
    output logic [15:0]                     pkt_tag,      // Packet tag
    output logic                            pkt_csum_req, // Checksum wanted
    output logic                            pkt_crc_add,  // Append CRC
    output logic                            pkt_pad_add,  // Pad short frame
    output logic                            pkt_opt_valid,// Options updated
    input  wire logic [tbu_pkg::ADDR_W-1:0] reg_addr,     // Register address
    input  wire logic [31:0]                reg_wdata,    // Write data
    input  wire logic                       reg_wr,       // Write strobe
    input  wire logic                       reg_rd,       // Read strobe
    output logic [31:0]                     reg_rdata     // Read data
);
    import tbu_pkg::*;

    typedef struct packed {
        tbu_state_t  state;
        logic [2:0]  skip;
        logic [10:0] data_dw;
        logic [10:0] pad_dw;
        logic [1:0]  lane0;
        logic [1:0]  endl;
        logic        first_dw;
        logic        fs;
        logic        ls;
        logic        ioc;
        logic        done;
        logic        csum_en;
        logic        stat_err;
        logic        stat_loaded;
        logic [15:0] tag;
        logic        csum_req;
        logic        crc_add;
        logic        pad_add;
        logic        opt_v;
        logic [31:0] rdata;
    } tbu_top_t;

    tbu_top_t st_r;
    tbu_top_t st_nxt;

    logic              fire;
    logic              ser_ready;
    logic              ser_load;
    logic              ser_last;
    logic [1:0]        ser_lo;
    logic [1:0]        ser_hi;
    logic              len_err;
    logic [4:0]        ofs;
    logic [CNT_W-1:0]  cnt;
    logic [11:0]       end_b;
    logic [11:0]       mask;
    logic [11:0]       tot_b;
    logic [11:0]       sum3;
    logic [10:0]       ceil_dw;
    logic [10:0]       tot_dw;
    logic [10:0]       new_data;
    logic [10:0]       new_pad;

    ////////////////////////////////////////////////////////////////////////
    // Command A geometry

    // Only the documented fields are sliced out; reserved bits never reach
    // any decision
    assign ofs   = in_data[CMDA_OFS_LSB +: 5];
    assign cnt   = in_data[CNT_W-1:0];
    assign end_b = {7'h00, ofs} + {1'b0, cnt};

    // Reserved alignment code falls back to word alignment
    always_comb begin
        unique case (in_data[CMDA_ALIGN_LSB +: 2])
            ALIGN_16: mask = MASK_16;
            ALIGN_32: mask = MASK_32;
            default:  mask = MASK_4;
        endcase
    end

    assign tot_b    = (end_b + mask) & ~mask;
    assign sum3     = end_b + MASK_4;
    assign ceil_dw  = {1'b0, sum3[11:2]};
    assign tot_dw   = {1'b0, tot_b[11:2]};
    // An empty buffer forwards nothing; its span past the skipped offset words is filler
    assign new_data = (cnt == '0) ? 11'h000
                                  : ceil_dw - {8'h00, ofs[4:2]};
    assign new_pad  = (cnt == '0) ? tot_dw - {8'h00, ofs[4:2]}
                                  : tot_dw - ceil_dw;

    function automatic tbu_state_t tbu_pick(input logic [2:0]  s,
                                            input logic [10:0] d,
                                            input logic [10:0] p);
        if (s != 3'h0) begin
            return ST_SKIP;
        end else if (d != 11'h000) begin
            return ST_DATA;
        end else if (p != 11'h000) begin
            return ST_PAD;
        end
        return ST_CMDA;
    endfunction : tbu_pick

    ////////////////////////////////////////////////////////////////////////
    // Parser

    // Skip and filler words are swallowed at full rate; only payload
    // words wait on the serialiser
    assign in_ready = (st_r.state == ST_DATA) ? ser_ready : 1'b1;
    assign fire     = in_valid && in_ready;
    assign ser_load = in_valid && (st_r.state == ST_DATA);
    assign ser_lo   = st_r.first_dw ? st_r.lane0 : 2'h0;
    assign ser_hi   = (st_r.data_dw == 11'h001) ? st_r.endl : 2'h3;
    assign ser_last = (st_r.data_dw == 11'h001) && st_r.ls;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.opt_v = 1'b0;
        st_nxt.done  = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        if (fire) begin
            unique case (st_r.state)
                ST_CMDA: begin
                    st_nxt.fs       = in_data[CMDA_FS_BIT];
                    st_nxt.ls       = in_data[CMDA_LS_BIT];
                    st_nxt.ioc      = in_data[CMDA_IOC_BIT];
                    st_nxt.skip     = ofs[4:2];
                    st_nxt.data_dw  = new_data;
                    st_nxt.pad_dw   = new_pad;
                    st_nxt.lane0    = ofs[1:0];
                    st_nxt.endl     = end_b[1:0] - 2'h1;
                    st_nxt.first_dw = 1'b1;
                    if (in_data[CMDA_FS_BIT]) begin
                        st_nxt.state = ST_CMDB;
                    end else begin
                        st_nxt.state = tbu_pick(ofs[4:2], new_data,
                                                new_pad);
                    end
                end
                ST_CMDB: begin
                    st_nxt.tag      = in_data[CMDB_TAG_LSB +: 16];
                    st_nxt.csum_req = in_data[CMDB_CK_BIT] && st_r.fs
                                      && st_r.csum_en;
                    st_nxt.crc_add  = !in_data[CMDB_NOCRC_BIT]
                                      || in_data[CMDB_NOPAD_BIT];
                    st_nxt.pad_add  = !in_data[CMDB_NOPAD_BIT];
                    st_nxt.opt_v    = 1'b1;
                    st_nxt.state    = tbu_pick(st_r.skip, st_r.data_dw,
                                               st_r.pad_dw);
                end
                ST_SKIP: begin
                    st_nxt.skip  = st_r.skip - 3'h1;
                    st_nxt.state = tbu_pick(st_nxt.skip, st_r.data_dw,
                                            st_r.pad_dw);
                end
                ST_DATA: begin
                    st_nxt.first_dw = 1'b0;
                    st_nxt.data_dw  = st_r.data_dw - 11'h001;
                    st_nxt.state    = tbu_pick(3'h0, st_nxt.data_dw,
                                               st_r.pad_dw);
                end
                ST_PAD: begin
                    st_nxt.pad_dw = st_r.pad_dw - 11'h001;
                    st_nxt.state  = tbu_pick(3'h0, 11'h000,
                                             st_nxt.pad_dw);
                end
                default: begin
                    st_nxt.state = ST_CMDA;
                end
            endcase
            st_nxt.done = (st_nxt.state == ST_CMDA);
        end

        // Register file; hardware set wins over a software clear
        if (reg_wr && reg_addr == REG_CTRL) begin
            st_nxt.csum_en = reg_wdata[CTRL_CSUM_EN_BIT];
        end
        if (reg_wr && reg_addr == REG_STAT) begin
            if (reg_wdata[STAT_ERR_BIT]) begin
                st_nxt.stat_err = 1'b0;
            end
            if (reg_wdata[STAT_LOADED_BIT]) begin
                st_nxt.stat_loaded = 1'b0;
            end
        end
        if (len_err) begin
            st_nxt.stat_err = 1'b1;
        end
        if (st_r.done && st_r.ioc) begin
            st_nxt.stat_loaded = 1'b1;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: st_nxt.rdata[CTRL_CSUM_EN_BIT] = st_r.csum_en;
                REG_STAT: begin
                    st_nxt.rdata[STAT_ERR_BIT]    = st_r.stat_err;
                    st_nxt.rdata[STAT_LOADED_BIT] = st_r.stat_loaded;
                end
                REG_TAG:  st_nxt.rdata[15:0] = st_r.tag;
                default:  st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r         <= '0;
            st_r.state   <= ST_CMDA;
            st_r.csum_en <= CTRL_CSUM_EN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pkt_tag       = st_r.tag;
    assign pkt_csum_req  = st_r.csum_req;
    assign pkt_crc_add   = st_r.crc_add;
    assign pkt_pad_add   = st_r.pad_add;
    assign pkt_opt_valid = st_r.opt_v;
    assign reg_rdata     = st_r.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Byte path and length check

    tbu_lane_ser u_ser (
        .clk       (clk),
        .nrst      (nrst),
        .ld_valid  (ser_load),
        .ld_ready  (ser_ready),
        .ld_word   (in_data),
        .ld_lo     (ser_lo),
        .ld_hi     (ser_hi),
        .ld_last   (ser_last),
        .out_byte  (out_byte),
        .out_valid (out_valid),
        .out_last  (out_last),
        .out_ready (out_ready)
    );

    tbu_len_chk u_len (
        .clk       (clk),
        .nrst      (nrst),
        .add_v     (fire && st_r.state == ST_CMDA),
        .add_first (in_data[CMDA_FS_BIT]),
        .add_cnt   (cnt),
        .plen_v    (fire && st_r.state == ST_CMDB),
        .plen      (in_data[CNT_W-1:0]),
        .chk_v     (st_r.done && st_r.ls),
        .err       (len_err)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence seq_cmdb_taken;
        fire && st_r.state == ST_CMDB;
    endsequence

    AST_CSUM_REQ: assert property (@(posedge clk) disable iff (!nrst)
        seq_cmdb_taken |=> (pkt_opt_valid && pkt_csum_req ==
            ($past(in_data[CMDB_CK_BIT]) && $past(st_r.csum_en))))
        else $error("checksum request wrong");
    AST_CRC_ADD: assert property (@(posedge clk) disable iff (!nrst)
        seq_cmdb_taken |=> pkt_crc_add == ($past(!in_data[CMDB_NOCRC_BIT])
            || $past(in_data[CMDB_NOPAD_BIT])))
        else $error("crc append decision wrong");
    AST_NOPAD_CRC: assert property (@(posedge clk) disable iff (!nrst)
        (seq_cmdb_taken and in_data[CMDB_NOPAD_BIT]) |=>
            (pkt_crc_add && !pkt_pad_add))
        else $error("crc dropped while padding suppressed");
    AST_TAG: assert property (@(posedge clk) disable iff (!nrst)
        seq_cmdb_taken |=> pkt_tag == $past(in_data[31:16]))
        else $error("packet tag not copied");
    AST_FS_CMDB: assert property (@(posedge clk) disable iff (!nrst)
        (fire && st_r.state == ST_CMDA) |=>
            ((st_r.state == ST_CMDB) == $past(in_data[CMDA_FS_BIT])))
        else $error("command B expectation wrong");
    AST_NO_FILLER: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.state == ST_SKIP || st_r.state == ST_PAD) |-> !ser_load)
        else $error("skip or filler word forwarded");
    AST_ERR_FLAG: assert property (@(posedge clk) disable iff (!nrst)
        len_err |=> st_r.stat_err)
        else $error("transmit error flag not set");
    AST_LOADED: assert property (@(posedge clk) disable iff (!nrst)
        (st_r.done && st_r.ioc) |=> st_r.stat_loaded ##1
            (st_r.stat_loaded || $past(reg_wr)))
        else $error("buffer loaded flag not raised");
endmodule : tbu_unpacker
`default_nettype wire

//--- tbu_unpacker_bench.sv
/* Bench for the unpacker: random packets, register checks, verdict.
   Assumes tbu_host_model drives the FIFO side. */
`timescale 1ns/1ps
`default_nettype none
module tbu_unpacker_bench;
    import tbu_pkg::*;
    logic clk = 0, nrst = 0, out_ready = 0, reg_wr = 0, reg_rd = 0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0, in_data, reg_rdata, rd;
    logic        in_valid, in_ready, out_valid, out_last;
    logic        csum, crc, pad, optv, hung = 1'b0;
    logic [7:0]  out_byte, got[$];
    logic        lastq[$];
    logic [15:0] tag;
    int          failures = 0, samples_checked = 0, opt_n = 0;
    tbu_unpacker uut (.clk(clk), .nrst(nrst), .in_data(in_data),
        .in_valid(in_valid), .in_ready(in_ready), .out_byte(out_byte),
        .out_valid(out_valid), .out_last(out_last), .out_ready(out_ready),
        .pkt_tag(tag), .pkt_csum_req(csum), .pkt_crc_add(crc),
        .pkt_pad_add(pad), .pkt_opt_valid(optv), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    tbu_host_model host (.clk(clk), .in_ready(in_ready), .in_data(in_data),
        .in_valid(in_valid));
    always #2 clk = ~clk;
    ////////////////////////////////////////
    // Store side stalls at random
    always @(posedge clk) begin
        out_ready <= ($urandom_range(2) != 0);
        if (optv)
            opt_n <= opt_n + 1;
        if (out_valid && out_ready) begin
            got.push_back(out_byte);
            lastq.push_back(out_last);
        end
    end
    task print_verdict;
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task reg_w(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_w
    task reg_r(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rd = reg_rdata;
    endtask : reg_r
    function automatic logic [2:0] opts(logic ck, en, nc, np);
        return {ck & en, !nc | np, !np};
    endfunction : opts
    task automatic run_pkt(input int n);
        int          cnt, c1, t;
        logic        en, ioc, bad, sp;
        logic [2:0]  o;
        logic [10:0] pl;
        logic [31:0] b;
        logic [7:0]  d[$];
        cnt = $urandom_range(40, 1);
        sp  = (cnt > 8) && n[1];
        c1  = sp ? $urandom_range(cnt - 1, 1) : cnt;
        en  = n[0];
        ioc = $urandom_range(1);
        bad = (n % 5 == 0);
        pl  = 11'(cnt + bad);
        b   = {16'($urandom), 1'b0, 3'($urandom), 1'b0, pl};
        for (int i = 0; i < cnt; i++)
            d.push_back(8'($urandom));
        reg_w(REG_CTRL, {31'h0, en});
        host.put_buf({ioc & !sp, 5'h0, 2'(n % 3), 3'h0, 5'($urandom), 2'h0,
            1'b1, !sp, 1'b0, 11'(c1)}, b, d[0:c1-1]);
        if (sp)
            host.put_buf({ioc, 5'h0, 2'(n % 3), 3'h0, 5'($urandom), 2'h0,
                2'h1, 1'b0, 11'(cnt - c1)}, 32'h0, d[c1:$]);
        for (t = 0; t < 3000 && (got.size() < cnt || host.q.size() != 0); t++)
            @(posedge clk);
        if (t == 3000) begin
            failures++;
            hung = 1'b1;
            return;
        end
        repeat (4) @(posedge clk);
        chk(got.size(), cnt);
        for (int i = 0; i < cnt; i++) begin
            chk(got[i], d[i]);
            chk(lastq[i], i == cnt - 1);
        end
        got.delete();
        lastq.delete();
        o = opts(b[CMDB_CK_BIT], en, b[CMDB_NOCRC_BIT], b[CMDB_NOPAD_BIT]);
        chk(tag, b[31:16]);
        chk(opt_n, n + 1);
        reg_r(REG_TAG);
        chk(rd, {16'h0, b[31:16]});
        chk({csum, crc, pad}, o);
        reg_r(REG_STAT);
        chk(rd, {30'h0, ioc, bad});
        reg_w(REG_STAT, 32'h3);
    endtask : run_pkt
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h20897d69));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        reg_r(REG_CTRL);
        chk(rd, 32'h0);
        reg_r(REG_STAT);
        chk(rd, 32'h0);
        reg_r(4'hC);
        chk(rd, 32'h0);
        for (int n = 0; n < 40 && !hung; n++)
            run_pkt(n);
        print_verdict();
    end
endmodule : tbu_unpacker_bench
`default_nettype wire
